/* File: core/tpfm_pkg.sv */
package tpfm_pkg;

   // ----------------------------------------------------------------
   // Frame bit positions (first bit of a frame is position 1)
   // ----------------------------------------------------------------
   typedef logic [12:0] tpfm_pos_t;

   localparam tpfm_pos_t POS_FIRST = 13'h0001;
   localparam tpfm_pos_t POS_SYNC_LAST = 13'h000E;
   localparam tpfm_pos_t POS_LOSS = 13'h000F;
   localparam tpfm_pos_t POS_BLOCK_ERR = 13'h0010;
   localparam tpfm_pos_t POS_PL1_FIRST = 13'h0011;
   localparam tpfm_pos_t POS_PL1_LAST = 13'h049C;
   localparam tpfm_pos_t POS_OH1_FIRST = 13'h049D;
   localparam tpfm_pos_t POS_OH1_LAST = 13'h04A6;
   localparam tpfm_pos_t POS_PL2_FIRST = 13'h04A7;
   localparam tpfm_pos_t POS_PL2_LAST = 13'h0932;
   localparam tpfm_pos_t POS_OH2_FIRST = 13'h0933;
   localparam tpfm_pos_t POS_OH2_LAST = 13'h093C;
   localparam tpfm_pos_t POS_PL3_FIRST = 13'h093D;
   localparam tpfm_pos_t POS_PL3_LAST = 13'h0DC8;
   localparam tpfm_pos_t POS_OH3_FIRST = 13'h0DC9;
   localparam tpfm_pos_t POS_OH3_LAST = 13'h0DD2;
   localparam tpfm_pos_t POS_PL4_FIRST = 13'h0DD3;
   localparam tpfm_pos_t POS_PL4_LAST = 13'h125E;
   localparam tpfm_pos_t POS_STUFF_FIRST = 13'h125F;
   localparam tpfm_pos_t POS_STUFF_LAST = 13'h1262;

   // Double seven-symbol Barker pattern, sent MSB first
   localparam logic [13:0] SYNC_WORD = 14'h3972;
   // Power status fill when this end is not the network termination
   localparam logic PS_IDLE = 1'h1;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_OH = 4'h1;
   localparam logic [3:0] REG_EOC = 4'h2;
   localparam logic [3:0] REG_STUFF = 4'h3;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_IRQ_STAT = 4'h5;
   localparam logic [3:0] REG_IRQ_CLR = 4'h6;
   localparam logic [3:0] REG_IRQ_EN = 4'h7;

   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_DIR_BIT = 1;
   localparam int IRQ_FRAME_BIT = 0;
   localparam int IRQ_LONG_BIT = 1;
   localparam int IRQ_UNDER_BIT = 2;

   localparam logic [1:0] CTRL_RST = 2'h0;
   localparam logic [12:0] EOC_RST = 13'h0000;
   localparam logic [3:0] STUFF_RST = 4'h0;
   localparam logic [2:0] IRQ_RST = 3'h0;

   // Loose overhead bits of one frame, low bit first in the register
   typedef struct packed {
      logic [5:0] spare;
      logic power_status_bit_two;
      logic power_status_bit_one;
      logic ready;
      logic regen_present;
      logic bipolar_viol;
      logic far_block_err;
      logic loss_of_signal;
   } tpfm_oh_t;

   localparam tpfm_oh_t OH_RST = 13'h0000;

   // Stuffing quat pair: sign then magnitude, first quat first
   typedef struct packed {
      logic second_stuff_magnitude;
      logic second_stuff_sign;
      logic first_stuff_magnitude;
      logic first_stuff_sign;
   } tpfm_stuff_t;

endpackage

/* File: core/tpfm_pos_cnt.sv */
`timescale 1ns/100ps

module tpfm_pos_cnt #(
   parameter int W = 13,
   parameter logic [W-1:0] FIRST = 13'h0001
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Control
   input wire logic clr,
   input wire logic step,
   input wire logic wrap,
   // Position
   output logic [W-1:0] count
);

   // Clear wins so a stopped framer always restarts at bit one
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= FIRST;
      end else if (ce) begin
         if (clr || (step && wrap)) begin
            count <= FIRST;
         end else if (step) begin
            count <= count + W'(1);
         end
      end
   end

endmodule // tpfm_pos_cnt

/* File: core/tpfm_framer.sv */
`timescale 1ns/100ps

module tpfm_framer (
   // Clock, reset, freeze
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Line bit timing and stuffing demand
   input wire logic bit_en,
   input wire logic stuff_req,
   // Payload source
   input wire logic payload_bit,
   input wire logic payload_valid,
   // CRC of previous frame, crc1 in bit 0
   input wire logic [5:0] crc_bits,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // Line side
   output logic tx_bit,
   output logic tx_valid,
   output logic frame_start,
   output logic payload_take,
   // Interrupt
   output logic irq
);

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [1:0] ctrl_q;
   tpfm_pkg::tpfm_oh_t oh_q, oh_sh_q;
   logic [12:0] eoc_q, eoc_sh_q;
   tpfm_pkg::tpfm_stuff_t stuff_q, stuff_sh_q;
   logic [5:0] crc_sh_q;
   logic [2:0] irq_stat_q, irq_stat_d, irq_en_q;
   logic [7:0] frame_cnt_q;
   logic long_q;
   logic [15:0] rdata_q;
   logic tx_bit_q, tx_valid_q, frame_start_q, payload_take_q, irq_q;

   logic run, is_upstream, step, wrap;
   logic [12:0] pos;

   assign run = ctrl_q[tpfm_pkg::CTRL_RUN_BIT];
   assign is_upstream = ctrl_q[tpfm_pkg::CTRL_DIR_BIT];
   assign step = run & bit_en;

   // ----------------------------------------------------------------
   // Frame position
   // ----------------------------------------------------------------
   // Pair is decided once, at the last payload bit, so never single
   assign wrap = (pos == tpfm_pkg::POS_PL4_LAST && !stuff_req) ||
                 (pos == tpfm_pkg::POS_STUFF_LAST);

   tpfm_pos_cnt #(
      .W(13),
      .FIRST(tpfm_pkg::POS_FIRST)
   ) u_pos (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .clr(!run),
      .step(step),
      .wrap(wrap),
      .count(pos)
   );

   // ----------------------------------------------------------------
   // Slot decode
   // ----------------------------------------------------------------
   logic in_sync, in_pl, in_oh1, in_oh2, in_oh3, in_stuff;
   logic in_pl1, in_pl2, in_pl3, in_pl4;
   assign in_sync = pos <= tpfm_pkg::POS_SYNC_LAST;
   assign in_pl1 = pos >= tpfm_pkg::POS_PL1_FIRST &&
                   pos <= tpfm_pkg::POS_PL1_LAST;
   assign in_pl2 = pos >= tpfm_pkg::POS_PL2_FIRST &&
                   pos <= tpfm_pkg::POS_PL2_LAST;
   assign in_pl3 = pos >= tpfm_pkg::POS_PL3_FIRST &&
                   pos <= tpfm_pkg::POS_PL3_LAST;
   assign in_pl4 = pos >= tpfm_pkg::POS_PL4_FIRST &&
                   pos <= tpfm_pkg::POS_PL4_LAST;
   assign in_pl = in_pl1 | in_pl2 | in_pl3 | in_pl4;
   assign in_oh1 = pos >= tpfm_pkg::POS_OH1_FIRST &&
                   pos <= tpfm_pkg::POS_OH1_LAST;
   assign in_oh2 = pos >= tpfm_pkg::POS_OH2_FIRST &&
                   pos <= tpfm_pkg::POS_OH2_LAST;
   assign in_oh3 = pos >= tpfm_pkg::POS_OH3_FIRST &&
                   pos <= tpfm_pkg::POS_OH3_LAST;
   assign in_stuff = pos >= tpfm_pkg::POS_STUFF_FIRST;

   // Offsets into the sync word, overhead group and stuff pair
   logic [12:0] sync_off, oh_off, stuff_off;
   assign sync_off = tpfm_pkg::POS_SYNC_LAST - pos;
   assign oh_off = in_oh1 ? pos - tpfm_pkg::POS_OH1_FIRST :
                   in_oh2 ? pos - tpfm_pkg::POS_OH2_FIRST :
                   pos - tpfm_pkg::POS_OH3_FIRST;
   assign stuff_off = pos - tpfm_pkg::POS_STUFF_FIRST;

   // ----------------------------------------------------------------
   // Overhead groups, slot 0 in bit 0
   // ----------------------------------------------------------------
   logic ps_one, ps_two;
   logic [9:0] grp1, grp2, grp3, grp_sel;
   // Power status carries meaning only toward the line termination
   assign ps_one = is_upstream ? oh_sh_q.power_status_bit_one
                               : tpfm_pkg::PS_IDLE;
   assign ps_two = is_upstream ? oh_sh_q.power_status_bit_two
                               : tpfm_pkg::PS_IDLE;
   assign grp1 = {eoc_sh_q[4], oh_sh_q.bipolar_viol, ps_two, ps_one,
                  crc_sh_q[1:0], eoc_sh_q[3:0]};
   assign grp2 = {oh_sh_q.spare[2:0], oh_sh_q.regen_present,
                  crc_sh_q[3:2], eoc_sh_q[8:5]};
   assign grp3 = {oh_sh_q.spare[5:4], oh_sh_q.ready,
                  oh_sh_q.spare[3], crc_sh_q[5:4], eoc_sh_q[12:9]};
   assign grp_sel = in_oh1 ? grp1 : in_oh2 ? grp2 : grp3;

   // ----------------------------------------------------------------
   // Bit selection
   // ----------------------------------------------------------------
   logic under, sel_bit;
   logic [3:0] stuff_vec;
   assign stuff_vec = stuff_sh_q;
   // An empty source sends zero rather than stalling the line
   assign under = in_pl & !payload_valid;
   assign sel_bit = in_sync ? tpfm_pkg::SYNC_WORD[sync_off[3:0]] :
                    pos == tpfm_pkg::POS_LOSS ?
                       oh_sh_q.loss_of_signal :
                    pos == tpfm_pkg::POS_BLOCK_ERR ?
                       oh_sh_q.far_block_err :
                    in_pl ? payload_bit & payload_valid :
                    in_stuff ? stuff_vec[stuff_off[1:0]] :
                    grp_sel[oh_off[3:0]];

   // Line outputs, registered for clean timing toward the coder
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_bit_q <= 1'h0;
         tx_valid_q <= 1'h0;
         frame_start_q <= 1'h0;
         payload_take_q <= 1'h0;
      end else if (ce) begin
         tx_bit_q <= step ? sel_bit : tx_bit_q;
         tx_valid_q <= step;
         frame_start_q <= step && pos == tpfm_pkg::POS_FIRST;
         payload_take_q <= step && in_pl;
      end
   end

   // Shadow copies taken at bit one so a frame never tears
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         oh_sh_q <= tpfm_pkg::OH_RST;
         eoc_sh_q <= tpfm_pkg::EOC_RST;
         stuff_sh_q <= tpfm_pkg::STUFF_RST;
         crc_sh_q <= 6'h00;
      end else if (ce && step && pos == tpfm_pkg::POS_FIRST) begin
         oh_sh_q <= oh_q;
         eoc_sh_q <= eoc_q;
         stuff_sh_q <= stuff_q;
         crc_sh_q <= crc_bits;
      end
   end

   // Frame bookkeeping
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         frame_cnt_q <= 8'h00;
         long_q <= 1'h0;
      end else if (ce && step && wrap) begin
         frame_cnt_q <= frame_cnt_q + 8'h01;
         long_q <= pos == tpfm_pkg::POS_STUFF_LAST;
      end
   end

   // ----------------------------------------------------------------
   // Register port
   // ----------------------------------------------------------------
   logic wr_ctrl, wr_oh, wr_eoc, wr_stuff, wr_clr, wr_en;
   assign wr_ctrl = reg_wr && reg_addr == tpfm_pkg::REG_CTRL;
   assign wr_oh = reg_wr && reg_addr == tpfm_pkg::REG_OH;
   assign wr_eoc = reg_wr && reg_addr == tpfm_pkg::REG_EOC;
   assign wr_stuff = reg_wr && reg_addr == tpfm_pkg::REG_STUFF;
   assign wr_clr = reg_wr && reg_addr == tpfm_pkg::REG_IRQ_CLR;
   assign wr_en = reg_wr && reg_addr == tpfm_pkg::REG_IRQ_EN;

   // Writable registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= tpfm_pkg::CTRL_RST;
         oh_q <= tpfm_pkg::OH_RST;
         eoc_q <= tpfm_pkg::EOC_RST;
         stuff_q <= tpfm_pkg::STUFF_RST;
         irq_en_q <= tpfm_pkg::IRQ_RST;
      end else if (ce) begin
         if (wr_ctrl) ctrl_q <= reg_wdata[1:0];
         if (wr_oh) oh_q <= reg_wdata[12:0];
         if (wr_eoc) eoc_q <= reg_wdata[12:0];
         if (wr_stuff) stuff_q <= reg_wdata[3:0];
         if (wr_en) irq_en_q <= reg_wdata[2:0];
      end
   end

   // Sticky events; a new event wins over a clear in the same cycle
   logic [2:0] irq_evt;
   assign irq_evt[tpfm_pkg::IRQ_FRAME_BIT] =
      step && pos == tpfm_pkg::POS_FIRST;
   assign irq_evt[tpfm_pkg::IRQ_LONG_BIT] =
      step && pos == tpfm_pkg::POS_STUFF_LAST;
   assign irq_evt[tpfm_pkg::IRQ_UNDER_BIT] = step && under;
   assign irq_stat_d = (irq_stat_q & ~(wr_clr ? reg_wdata[2:0] : 3'h0))
                       | irq_evt;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat_q <= tpfm_pkg::IRQ_RST;
         irq_q <= 1'h0;
      end else if (ce) begin
         irq_stat_q <= irq_stat_d;
         irq_q <= |(irq_stat_d & irq_en_q);
      end
   end

   // Read mux; unmapped and write-only offsets read as zero
   logic [15:0] rd_mux;
   assign rd_mux =
      reg_addr == tpfm_pkg::REG_CTRL ? {14'h0000, ctrl_q} :
      reg_addr == tpfm_pkg::REG_OH ? {3'h0, oh_q} :
      reg_addr == tpfm_pkg::REG_EOC ? {3'h0, eoc_q} :
      reg_addr == tpfm_pkg::REG_STUFF ? {12'h000, stuff_q} :
      reg_addr == tpfm_pkg::REG_STATUS ?
         {6'h00, long_q, run, frame_cnt_q} :
      reg_addr == tpfm_pkg::REG_IRQ_STAT ? {13'h0000, irq_stat_q} :
      reg_addr == tpfm_pkg::REG_IRQ_EN ? {13'h0000, irq_en_q} :
      16'h0000;

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= 16'h0000;
      end else if (ce) begin
         rdata_q <= reg_rd ? rd_mux : 16'h0000;
      end
   end

   assign reg_rdata = rdata_q;
   assign tx_bit = tx_bit_q;
   assign tx_valid = tx_valid_q;
   assign frame_start = frame_start_q;
   assign payload_take = payload_take_q;
   assign irq = irq_q;

endmodule // tpfm_framer

/* File: dv/tpfm_framer_chk_sva.sv */
`timescale 1ns/100ps
// ---------------------------------------------
// Line and register port checker
// ---------------------------------------------
module tpfm_framer_chk (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Inputs seen
   input wire logic ce,
   input wire logic bit_en,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   // Outputs seen
   input wire logic [15:0] reg_rdata,
   input wire logic tx_bit,
   input wire logic tx_valid,
   input wire logic frame_start,
   input wire logic payload_take,
   input wire logic irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic [12:0] pos_q;
   logic seen_q, ce_q;
   // A frozen framer holds its outputs; only a clocked cycle is new
   wire fresh = tx_valid && ce_q;
   wire [12:0] pos_d = frame_start ? 13'h0001 : pos_q + 13'h0001;
   // Payload slots of the frame map
   wire in_pl = (pos_d >= 13'd17 && pos_d <= 13'd1180) ||
      (pos_d >= 13'd1191 && pos_d <= 13'd2354) ||
      (pos_d >= 13'd2365 && pos_d <= 13'd3528) ||
      (pos_d >= 13'd3539 && pos_d <= 13'd4702);
   // Own position count; only frame_start realigns it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pos_q <= 13'h0000;
         seen_q <= 1'b0;
         ce_q <= 1'b0;
      end else begin
         ce_q <= ce;
         if (fresh) begin
            pos_q <= pos_d;
            seen_q <= seen_q | frame_start;
         end
      end
   end
   a_take_map: assert property (
      fresh |-> payload_take == in_pl)
      else $error("payload flag off the frame map");
   a_take_valid: assert property (payload_take |-> tx_valid)
      else $error("payload flag without line bit");
   a_start_valid: assert property (frame_start |-> tx_valid)
      else $error("frame start without line bit");
   a_sync_word: assert property (
      fresh && pos_d <= 13'd14 |->
      tx_bit == tpfm_pkg::SYNC_WORD[14 - int'(pos_d)])
      else $error("sync word bit wrong");
   a_frame_len: assert property (
      fresh && frame_start && seen_q |->
      pos_q == 13'd4702 || pos_q == 13'd4706)
      else $error("frame length neither short nor long");
   a_no_overrun: assert property (fresh |-> pos_d <= 13'd4706)
      else $error("frame ran past last stuff bit");
   // A held line bit during a freeze is the last one, not a new one
   a_valid_cause: assert property (tx_valid |->
      $past(bit_en) || !$past(ce) && $past(tx_valid))
      else $error("line bit without bit slot");
   a_rdata_idle: assert property ($past(ce) && !$past(reg_rd) |->
      reg_rdata == 16'h0000)
      else $error("read data outside read cycle");
   a_irq_off: assert property (ce && reg_wr &&
      reg_addr == tpfm_pkg::REG_IRQ_EN && reg_wdata[2:0] == 3'h0
      ##1 ce |=> !irq)
      else $error("interrupt stays after masking");
   c_long: cover property (fresh && frame_start && seen_q &&
      pos_q == 13'd4706);
   c_short: cover property (fresh && frame_start && seen_q &&
      pos_q == 13'd4702);
   c_irq: cover property ($rose(irq));
endmodule // tpfm_framer_chk

bind tpfm_framer tpfm_framer_chk u_chk (.clk, .rst_n, .ce, .bit_en,
   .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tx_bit,
   .tx_valid, .frame_start, .payload_take, .irq);

/* File: dv/tpfm_far_end.sv */
`timescale 1ns/100ps
// ---------------------------------------------
// Far-end transceiver and payload source
// ---------------------------------------------
module tpfm_far_end (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Line from the framer
   input wire logic tx_bit,
   input wire logic tx_valid,
   input wire logic frame_start,
   // Payload source control
   input wire logic starve,
   output logic payload_bit,
   output logic payload_valid,
   // Last complete frame
   output int nframes,
   output int last_len,
   output logic rx_last [1:4706]
);
   logic rx_cur [1:4706];
   int pos;
   logic tog_q, ce_q;
   wire fresh;
   // A frozen framer holds tx_valid; only a clocked cycle is a new bit
   assign fresh = tx_valid && ce_q;
   // Starved source shows a toggling, not a held, bit
   assign payload_valid = !starve;
   assign payload_bit = starve ? tog_q : 1'b1;
   // Length found only by the next sync word start
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         nframes <= 0;
         last_len <= 0;
         pos <= 0;
         tog_q <= 1'b0;
         ce_q <= 1'b0;
      end else begin
         tog_q <= ~tog_q;
         ce_q <= ce;
         if (fresh && frame_start) begin
            if (pos > 0) begin
               rx_last <= rx_cur;
               last_len <= pos;
               nframes <= nframes + 1;
            end
            pos <= 1;
            rx_cur[1] <= tx_bit;
         end else if (fresh && pos > 0 && pos < 4706) begin
            pos <= pos + 1;
            rx_cur[pos + 1] <= tx_bit;
         end
      end
   end
endmodule // tpfm_far_end

/* File: dv/tpfm_framer_test.sv */
`timescale 1ns/100ps
module tpfm_framer_test;
   logic clk, rst_n, ce, bit_en, stuff_req, payload_bit, payload_valid;
   logic starve, reg_wr, reg_rd, tx_bit, tx_valid, frame_start;
   logic payload_take, irq, upstream, pl;
   logic [5:0] crc_bits;
   logic [3:0] reg_addr, stf;
   logic [15:0] reg_wdata, reg_rdata;
   logic [12:0] eoc;
   tpfm_pkg::tpfm_oh_t oh;
   logic rx [1:4706];
   int errors, n_tests, nframes, last_len;
   logic [3:0] ra [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h7, 4'hF};

   tpfm_framer uut (.clk(clk), .rst_n(rst_n), .ce(ce), .bit_en(bit_en),
      .stuff_req(stuff_req), .payload_bit(payload_bit),
      .payload_valid(payload_valid), .crc_bits(crc_bits),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_bit(tx_bit),
      .tx_valid(tx_valid), .frame_start(frame_start),
      .payload_take(payload_take), .irq(irq));
   tpfm_far_end far (.clk(clk), .rst_n(rst_n), .ce(ce), .tx_bit(tx_bit),
      .tx_valid(tx_valid), .frame_start(frame_start), .starve(starve),
      .payload_bit(payload_bit), .payload_valid(payload_valid),
      .nframes(nframes), .last_len(last_len), .rx_last(rx));

   // ---------------------------------------------
   // Checking and bus tasks
   // ---------------------------------------------
   task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
         errors++;
      end
   endtask
   task automatic wr(logic [3:0] a, logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(logic [3:0] a, logic [15:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 check("read data", reg_rdata, exp);
   endtask
   task automatic wait_frames(int n);
      for (int i = 0; i < 12000 && nframes < n; i++) begin
         @(posedge clk);
         #1;
      end
      check("frames", 16'(nframes), 16'(n));
   endtask
   // Expected line bit from the programmed fields
   function automatic logic exp_bit(int p);
      logic [9:0] g [3];
      logic ps_a, ps_b;
      ps_a = upstream ? oh.power_status_bit_one : tpfm_pkg::PS_IDLE;
      ps_b = upstream ? oh.power_status_bit_two : tpfm_pkg::PS_IDLE;
      g[0] = {eoc[4], oh.bipolar_viol, ps_b, ps_a, crc_bits[1:0], eoc[3:0]};
      g[1] = {oh.spare[2:0], oh.regen_present, crc_bits[3:2], eoc[8:5]};
      g[2] = {oh.spare[5:4], oh.ready, oh.spare[3], crc_bits[5:4], eoc[12:9]};
      if (p <= 14) return tpfm_pkg::SYNC_WORD[14 - p];
      if (p == 15) return oh.loss_of_signal;
      if (p == 16) return oh.far_block_err;
      if (p >= 4703) return stf[p - 4703];
      if (p >= 3529 && p < 3539) return g[2][p - 3529];
      if (p >= 2355 && p < 2365) return g[1][p - 2355];
      if (p >= 1181 && p < 1191) return g[0][p - 1181];
      return pl;
   endfunction
   task automatic check_frame(int len);
      check("frame length", 16'(last_len), 16'(len));
      for (int p = 1; p <= len; p++) begin
         check("line bit", 16'(rx[p]), 16'(exp_bit(p)));
      end
   endtask
   task automatic stop_test();
      $display("errors %0d of %0d checks", errors, n_tests);
      if (errors == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // ---------------------------------------------
   // Clock, watchdog and main sequence
   // ---------------------------------------------
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Three frames take about 14200 cycles
   initial begin
      repeat (30000) @(posedge clk);
      errors++;
      stop_test();
   end
   initial begin
      {rst_n, ce, bit_en, stuff_req, starve, reg_wr, reg_rd} = 7'h00;
      {reg_addr, reg_wdata, crc_bits} = '0;
      {oh, eoc, stf, upstream, pl} = {13'h15A5, 13'h0B3C, 4'h6, 2'h3};
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      ce <= 1'b1;
      bit_en <= 1'b1;
      foreach (ra[i]) rd(ra[i], 16'h0000);
      crc_bits <= 6'h2D;
      stuff_req <= 1'b1;
      wr(tpfm_pkg::REG_OH, 16'(oh));
      wr(tpfm_pkg::REG_EOC, 16'(eoc));
      wr(tpfm_pkg::REG_STUFF, 16'(stf));
      rd(tpfm_pkg::REG_OH, 16'(oh));
      wr(tpfm_pkg::REG_IRQ_EN, 16'h0007);
      wr(tpfm_pkg::REG_CTRL, 16'h0003);
      // Long frame, network termination direction
      wait_frames(1);
      check_frame(4706);
      rd(tpfm_pkg::REG_STATUS, 16'h0301);
      rd(tpfm_pkg::REG_IRQ_STAT, 16'h0003);
      check("irq", 16'(irq), 16'h0001);
      wr(tpfm_pkg::REG_IRQ_CLR, 16'h0007);
      rd(tpfm_pkg::REG_IRQ_STAT, 16'h0000);
      stuff_req <= 1'b0;
      starve <= 1'b1;
      wr(tpfm_pkg::REG_CTRL, 16'h0001);
      // Short starved frame; then masked interrupt
      wait_frames(2);
      starve <= 1'b0;
      check("frame length", 16'(last_len), 16'd4702);
      check("starved bit", 16'(rx[4702]), 16'h0000);
      rd(tpfm_pkg::REG_STATUS, 16'h0102);
      rd(tpfm_pkg::REG_IRQ_STAT, 16'h0005);
      wr(tpfm_pkg::REG_IRQ_EN, 16'h0000);
      repeat (3) @(posedge clk);
      #1 check("irq", 16'(irq), 16'h0000);
      upstream = 1'b0;
      repeat (100) @(posedge clk);
      ce <= 1'b0;
      repeat (20) @(posedge clk);
      ce <= 1'b1;
      wait_frames(3);
      check_frame(4702);
      // Stopping clears run and keeps the frame count
      wr(tpfm_pkg::REG_CTRL, 16'h0000);
      rd(tpfm_pkg::REG_STATUS, 16'h0003);
      stop_test();
   end
endmodule // tpfm_framer_test
